// ==== dacp_defines.vh ====
/*
  constants for the dual converter pin control and output formatting block:
  register offsets, field positions, reset values and timing counts.
  assumes a 250 MHz system clock (4 ns period); the block is reached over a
  plain strobe port with read data one cycle after the read strobe.

  // How it works
  // - delay select pin picks long or short wait
  // - power down held at power-up freezes delay counter
  // - extended mode always uses short delay
  // - edge select picks rising or falling clock launch
  // - swing select sets output driver strength
  // - dual edge: one input feeds both converters
  // - floating delay pin selects dual edge, short delay
  // - extended mode chooses dual edge source input
  // - full power down stops all, q stops q
  // - powered-down channel outputs go high impedance
  // - calibration finishes before power down takes effect
  // - manual request ignored while powered down
  // - odd and even conversions go to separate buses
  // - one forwarded data clock serves all buses
  // - double rate mode: word per edge, quarter clock
  // - offset binary output, mid code 127/128
  // - calibration flag high, data clock stopped, during calibration
  // - manual calibration needs low count then high count
  // - request high at power-up skips power-on calibration
*/
`ifndef DACP_DEFINES_VH
`define DACP_DEFINES_VH

// register indices (byte address is four times the index)
`define DACP_IDX_CONFIG        4'h1
`define DACP_IDX_DES_ENABLE    4'hd
`define DACP_IDX_STATUS        4'h2

// configuration register fields
`define DACP_CFG_DDR_BIT       0
`define DACP_CFG_EDGE_BIT      1
`define DACP_CFG_SWING_BIT     2
`define DACP_CFG_RESET         16'h0006

// dual edge sampling enable register fields
`define DACP_DES_EN_BIT        15
`define DACP_DES_PHASE_BIT     14
`define DACP_DES_SRC_Q_BIT     13
`define DACP_DES_RESET         16'h0000

// status register fields
`define DACP_ST_CAL_BIT        0
`define DACP_ST_PD_BIT         1
`define DACP_ST_PDQ_BIT        2
`define DACP_ST_DES_BIT        3

// calibration timing, in input clock cycles
`define DACP_CAL_LOW_MIN       16'd1280
`define DACP_CAL_HIGH_MIN      16'd1280
`define DACP_CAL_RUN_CYCLES    24'd1400000
`define DACP_DLY_SHORT         26'd16777216
// the long wait is capped at the full range of the 26-bit delay counter
`define DACP_DLY_LONG          26'h3ffffff

`endif

// ==== dacp_sync.v ====
/*
  two flip-flop synchroniser for a single level from outside the clock domain.
  assumes the input is a pin level; only the second stage may be read.
*/
`timescale 1ns/1ps
module dacp_sync (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // level in and out
  input  wire d,
  output reg  q
);
  reg meta; // first stage, read by the second stage only

  // two stages, reset to zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ==== dacp_demux_lane.v ====
/*
  one converter lane: offset binary formatting and odd/even split onto two
  buses. assumes samples arrive one per sample strobe from the same clock.
*/
`timescale 1ns/1ps
module dacp_demux_lane (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // sample input, two's complement from the converter core
  input  wire       smp_valid,
  input  wire [7:0] smp_data,
  input  wire       flush,
  // demultiplexed buses
  output reg  [7:0] bus_odd,
  output reg  [7:0] bus_even
);
  reg odd_next; // which bus the next conversion goes to

  // alternate buses; flipping the sign bit gives offset binary
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      odd_next <= 1'b1;
      bus_odd  <= 8'h80;
      bus_even <= 8'h80;
    end else if (flush) begin
      // restart the pair order so odd is first after power-up
      odd_next <= 1'b1;
    end else if (smp_valid) begin
      odd_next <= ~odd_next;
      if (odd_next) begin
        bus_odd <= {~smp_data[7], smp_data[6:0]};
      end else begin
        bus_even <= {~smp_data[7], smp_data[6:0]};
      end
    end
  end
endmodule

// ==== dacp_top.v ====
/*
  pin control and output formatting of a dual 8-bit converter: power-on and
  manual calibration sequencing, power down, dual edge sampling routing,
  odd/even demultiplexing and the forwarded data clock.
  assumes the sample clock is SYS_CLK; control pins are asynchronous and are
  synchronised here; the three-level delay pin arrives as two decoded levels.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "dacp_defines.vh"
module dacp_top #(
  parameter [25:0] DLY_SHORT = `DACP_DLY_SHORT,
  parameter [25:0] DLY_LONG  = `DACP_DLY_LONG,
  parameter [23:0] CAL_RUN   = `DACP_CAL_RUN_CYCLES
) (
  // clock and reset
  input  wire        SYS_CLK,
  input  wire        RST_N,
  // control pins
  input  wire        CAL_DELAY_SELECT,
  input  wire        CAL_DELAY_FLOAT,
  input  wire        SERIAL_PORT_SELECT_N,
  input  wire        CAL_REQUEST,
  input  wire        FULL_POWER_DOWN,
  input  wire        Q_CHANNEL_POWER_DOWN,
  input  wire        OUTPUT_EDGE_SELECT,
  input  wire        OUTPUT_SWING_SELECT,
  // converter core samples, two's complement
  input  wire [7:0]  I_SAMPLE,
  input  wire [7:0]  Q_SAMPLE,
  // register port
  input  wire [3:0]  REG_ADDR,
  input  wire [15:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [15:0] REG_RDATA,
  // data outputs
  output reg  [7:0]  DI_ODD,
  output reg  [7:0]  DI_EVEN,
  output reg  [7:0]  DQ_ODD,
  output reg  [7:0]  DQ_EVEN,
  output reg         DI_OE,
  output reg         DQ_OE,
  output reg         OUTPUT_DATA_CLOCK,
  output reg         OUTPUT_DRIVE_HIGH,
  output reg         CALIBRATION_ACTIVE,
  output reg         I_INPUT_ACTIVE,
  output reg         Q_INPUT_ACTIVE
);
  // calibration states
  localparam [1:0] ST_DELAY = 2'd0;
  localparam [1:0] ST_IDLE  = 2'd1;
  localparam [1:0] ST_CAL   = 2'd2;
  localparam [1:0] ST_PD    = 2'd3;

  // synchronised pins
  wire dly_sel;       // delay select level
  wire dly_float;     // delay pin left floating
  wire ext_n;         // low selects extended control mode
  wire cal_req;       // manual calibration request
  wire pd;            // full power down
  wire q_channel_power_down;           // q channel power down
  wire edge_sel;      // output edge select
  wire swing_sel;     // output swing select

  dacp_sync u_s0 (.clk(SYS_CLK), .rst_n(RST_N), .d(CAL_DELAY_SELECT),     .q(dly_sel));
  dacp_sync u_s1 (.clk(SYS_CLK), .rst_n(RST_N), .d(CAL_DELAY_FLOAT),      .q(dly_float));
  dacp_sync u_s2 (.clk(SYS_CLK), .rst_n(RST_N), .d(SERIAL_PORT_SELECT_N), .q(ext_n));
  dacp_sync u_s3 (.clk(SYS_CLK), .rst_n(RST_N), .d(CAL_REQUEST),          .q(cal_req));
  dacp_sync u_s4 (.clk(SYS_CLK), .rst_n(RST_N), .d(FULL_POWER_DOWN),      .q(pd));
  dacp_sync u_s5 (.clk(SYS_CLK), .rst_n(RST_N), .d(Q_CHANNEL_POWER_DOWN), .q(q_channel_power_down));
  dacp_sync u_s6 (.clk(SYS_CLK), .rst_n(RST_N), .d(OUTPUT_EDGE_SELECT),   .q(edge_sel));
  dacp_sync u_s7 (.clk(SYS_CLK), .rst_n(RST_N), .d(OUTPUT_SWING_SELECT),  .q(swing_sel));

  // software registers
  reg [15:0] cfg;      // configuration register
  reg [15:0] des_en;   // dual edge sampling enable register
  wire       extended = ~ext_n;

  // register writes; only reachable in extended control mode
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg    <= `DACP_CFG_RESET;
      des_en <= `DACP_DES_RESET;
    end else if (REG_WR && extended) begin
      if (REG_ADDR == `DACP_IDX_CONFIG) begin
        // the controller must only do this with dual edge off
        cfg <= REG_WDATA;
      end else if (REG_ADDR == `DACP_IDX_DES_ENABLE) begin
        des_en <= REG_WDATA;
      end
    end
  end

  // effective mode selection
  wire des_mode  = extended ? des_en[`DACP_DES_EN_BIT] : dly_float;
  wire des_src_q = extended & des_en[`DACP_DES_SRC_Q_BIT];
  wire ddr_mode  = extended & cfg[`DACP_CFG_DDR_BIT];
  wire edge_eff  = extended ? cfg[`DACP_CFG_EDGE_BIT] : edge_sel;
  wire swing_eff = extended ? cfg[`DACP_CFG_SWING_BIT] : swing_sel;
  // short delay in extended mode or in dual edge mode
  wire [25:0] dly_target = (extended | des_mode | ~dly_sel) ? DLY_SHORT : DLY_LONG;

  // register reads, data one cycle after the strobe
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      if (REG_ADDR == `DACP_IDX_CONFIG) begin
        REG_RDATA <= cfg;
      end else if (REG_ADDR == `DACP_IDX_DES_ENABLE) begin
        REG_RDATA <= des_en;
      end else if (REG_ADDR == `DACP_IDX_STATUS) begin
        REG_RDATA <= {12'h000, des_mode, q_channel_power_down, pd, CALIBRATION_ACTIVE};
      end else begin
        REG_RDATA <= 16'h0000;   // unmapped reads as zero
      end
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

  // calibration sequencer state
  reg [1:0]  state;
  reg [25:0] dly_cnt;     // power-on delay counter
  reg [23:0] run_cnt;     // calibration length counter
  reg [15:0] low_cnt;     // request low time
  reg [15:0] high_cnt;    // request high time
  reg        armed;       // low time met, waiting for high time
  reg        skip_poc;    // request was high at power-up
  reg [1:0]  settle;      // edges since reset, until synchronised pins are real

  // manual request qualifier: low count then high count
  wire low_met  = (low_cnt >= `DACP_CAL_LOW_MIN);
  wire man_fire = armed && cal_req && (high_cnt == `DACP_CAL_HIGH_MIN - 16'd1);

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt  <= 16'h0000;
      high_cnt <= 16'h0000;
      armed    <= 1'b0;
    end else if ((state == ST_PD) || ((state == ST_DELAY) && pd)) begin
      // request ignored entirely while powered down
      low_cnt  <= 16'h0000;
      high_cnt <= 16'h0000;
      armed    <= 1'b0;
    end else if (!cal_req) begin
      high_cnt <= 16'h0000;
      if (!low_met) begin
        low_cnt <= low_cnt + 16'd1;
      end
      armed <= armed | low_met;
    end else begin
      low_cnt <= 16'h0000;
      if (man_fire) begin
        armed    <= 1'b0;
        high_cnt <= 16'h0000;
      end else if (armed) begin
        high_cnt <= high_cnt + 16'd1;
      end
    end
  end

  // main sequencer: delay, idle, calibrate, power down
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state    <= ST_DELAY;
      dly_cnt  <= 26'h0000000;
      run_cnt  <= 24'h000000;
      skip_poc <= 1'b0;
      settle   <= 2'h0;
    end else begin
      // synchronisers show their reset value for two edges; wait them out
      if (settle != 2'h3) begin
        settle <= settle + 2'h1;
      end
      case (state)
        ST_DELAY: begin
          if (settle != 2'h3) begin
            // take the request strap once its synchronised level is real
            if (settle == 2'h2) begin
              skip_poc <= cal_req;
            end
          end else if (man_fire && !pd) begin
            state   <= ST_CAL;
            run_cnt <= 24'h000000;
          end else if (pd) begin
            dly_cnt <= dly_cnt;                 // counter frozen
          end else if (dly_cnt >= dly_target - 26'd1) begin
            // skipped power-on calibration waits for a manual one
            state   <= skip_poc ? ST_IDLE : ST_CAL;
            run_cnt <= 24'h000000;
          end else begin
            dly_cnt <= dly_cnt + 26'd1;
          end
        end
        ST_IDLE: begin
          if (pd) begin
            state <= ST_PD;
          end else if (man_fire) begin
            state   <= ST_CAL;
            run_cnt <= 24'h000000;
          end
        end
        ST_CAL: begin
          // power down waits for the end of calibration
          if (run_cnt == CAL_RUN - 24'd1) begin
            state <= pd ? ST_PD : ST_IDLE;
          end else begin
            run_cnt <= run_cnt + 24'd1;
          end
        end
        default: begin
          if (!pd) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  wire calibrating = (state == ST_CAL);
  // a power-down pin held through the power-on wait also parks the outputs
  wire full_down   = (state == ST_PD) | ((state == ST_DELAY) & pd);
  wire q_down      = full_down | q_channel_power_down;

  // sample routing: dual edge feeds one input to both lanes
  wire [7:0] lane_i = (des_mode && des_src_q) ? Q_SAMPLE : I_SAMPLE;
  wire [7:0] lane_q = (des_mode && !des_src_q) ? I_SAMPLE : Q_SAMPLE;

  // buses from the two lanes
  wire [7:0] i_odd;
  wire [7:0] i_even;
  wire [7:0] q_odd;
  wire [7:0] q_even;

  // every clock is one conversion per lane; flushed while down
  dacp_demux_lane u_lane_i (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .smp_valid (~full_down),
    .smp_data  (lane_i),
    .flush     (full_down),
    .bus_odd   (i_odd),
    .bus_even  (i_even)
  );
  dacp_demux_lane u_lane_q (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .smp_valid (~q_down),
    .smp_data  (lane_q),
    .flush     (q_down),
    .bus_odd   (q_odd),
    .bus_even  (q_even)
  );

  // data clock divider: half rate normally, quarter rate in double rate
  reg [1:0] div;
  reg       launch;   // a new word pair is presented this cycle

  // one forwarded clock for all buses, stopped while calibrating
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div               <= 2'b00;
      OUTPUT_DATA_CLOCK <= 1'b0;
      launch            <= 1'b0;
    end else if (calibrating || full_down) begin
      div               <= 2'b00;
      OUTPUT_DATA_CLOCK <= 1'b0;
      launch            <= 1'b0;
    end else if (ddr_mode) begin
      // toggle every second clock: quarter rate, a word per edge
      div    <= div + 2'b01;
      launch <= div[0];
      if (div[0]) begin
        OUTPUT_DATA_CLOCK <= ~OUTPUT_DATA_CLOCK;
      end
    end else begin
      // words change on the chosen edge of the data clock
      div               <= 2'b00;
      OUTPUT_DATA_CLOCK <= ~OUTPUT_DATA_CLOCK;
      // armed while the clock sits on the chosen level, so the update meets its edge
      launch            <= (OUTPUT_DATA_CLOCK == edge_eff) ? 1'b1 : 1'b0;
    end
  end

  // output registers update on the launch edge; enables off while down
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DI_ODD             <= 8'h80;
      DI_EVEN            <= 8'h80;
      DQ_ODD             <= 8'h80;
      DQ_EVEN            <= 8'h80;
      DI_OE              <= 1'b0;
      DQ_OE              <= 1'b0;
      OUTPUT_DRIVE_HIGH  <= 1'b0;
      CALIBRATION_ACTIVE <= 1'b0;
      I_INPUT_ACTIVE     <= 1'b0;
      Q_INPUT_ACTIVE     <= 1'b0;
    end else begin
      if (launch) begin
        DI_ODD  <= i_odd;
        DI_EVEN <= i_even;
        DQ_ODD  <= q_odd;
        DQ_EVEN <= q_even;
      end
      DI_OE              <= ~full_down;
      DQ_OE              <= ~q_down;
      OUTPUT_DRIVE_HIGH  <= swing_eff;
      CALIBRATION_ACTIVE <= calibrating;
      // unused input deactivated in dual edge mode
      I_INPUT_ACTIVE     <= ~full_down & ~(des_mode & des_src_q);
      Q_INPUT_ACTIVE     <= ~q_down & ~(des_mode & ~des_src_q);
    end
  end
endmodule

// ==== dacp_chk.sv ====
/* checker for dacp_top: calibration, power down, launch edge, swing,
   routing and read port relations. assumes bind to dacp_top ports. */
`timescale 1ns/1ps
module dacp_chk #(
  parameter [23:0] CAL_RUN = 24'd100
) (
  // clock and reset
  input wire        SYS_CLK,
  input wire        RST_N,
  // control pins
  input wire        CAL_DELAY_FLOAT,
  input wire        SERIAL_PORT_SELECT_N,
  input wire        FULL_POWER_DOWN,
  input wire        Q_CHANNEL_POWER_DOWN,
  input wire        OUTPUT_EDGE_SELECT,
  input wire        OUTPUT_SWING_SELECT,
  // register port
  input wire        REG_RD,
  input wire [15:0] REG_RDATA,
  // outputs
  input wire [7:0]  DI_ODD,
  input wire        DI_OE,
  input wire        DQ_OE,
  input wire        OUTPUT_DATA_CLOCK,
  input wire        OUTPUT_DRIVE_HIGH,
  input wire        CALIBRATION_ACTIVE,
  input wire        I_INPUT_ACTIVE,
  input wire        Q_INPUT_ACTIVE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  reg [23:0] cal_cnt; // cycles the calibration flag has been high
  // count flag-high cycles; cleared while low so each run is measured alone
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) cal_cnt <= 24'h0;
    else cal_cnt <= CALIBRATION_ACTIVE ? cal_cnt + 24'h1 : 24'h0;
  end
  // pin mode settled for five cycles, the fifth of them bringing a fresh word on the bus
  sequence s_launch(logic e);
    (SERIAL_PORT_SELECT_N && OUTPUT_EDGE_SELECT == e)[*5] ##0 (DI_OE && $past(DI_OE) && $changed(DI_ODD));
  endsequence
  sequence s_pd_held;
    FULL_POWER_DOWN[*8];
  endsequence
  a_cal_clk_quiet: assert property (CALIBRATION_ACTIVE && $past(CALIBRATION_ACTIVE) |-> !OUTPUT_DATA_CLOCK)
    else $error("data clock runs in calibration");
  a_cal_run_len: assert property ($fell(CALIBRATION_ACTIVE) |-> cal_cnt >= CAL_RUN && cal_cnt <= CAL_RUN + 24'd2)
    else $error("calibration length wrong");
  a_pd_no_cal: assert property (s_pd_held |-> !$rose(CALIBRATION_ACTIVE))
    else $error("calibration started in power down");
  a_pd_outputs_off: assert property ((FULL_POWER_DOWN && !CALIBRATION_ACTIVE)[*5] |-> !DI_OE && !DQ_OE)
    else $error("outputs driven in power down");
  a_q_down_only: assert property ((Q_CHANNEL_POWER_DOWN && !CALIBRATION_ACTIVE)[*5] |-> !DQ_OE)
    else $error("q outputs driven in q power down");
  a_rise_launch: assert property (s_launch(1'b1) |-> $rose(OUTPUT_DATA_CLOCK))
    else $error("word not launched on rising clock");
  a_fall_launch: assert property (s_launch(1'b0) |-> $fell(OUTPUT_DATA_CLOCK))
    else $error("word not launched on falling clock");
  a_swing_follow: assert property ((SERIAL_PORT_SELECT_N && !FULL_POWER_DOWN && $stable(OUTPUT_SWING_SELECT))[*5]
    |-> OUTPUT_DRIVE_HIGH == OUTPUT_SWING_SELECT)
    else $error("drive strength not following pin");
  a_des_route: assert property ((SERIAL_PORT_SELECT_N && CAL_DELAY_FLOAT && !FULL_POWER_DOWN && !CALIBRATION_ACTIVE)[*5]
    |-> I_INPUT_ACTIVE && !Q_INPUT_ACTIVE)
    else $error("dual edge routing wrong");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data without read");
endmodule
bind dacp_top dacp_chk #(.CAL_RUN(CAL_RUN)) u_dacp_chk (.*);

// ==== dacp_rx_model.sv ====
/* capture logic at the far side: latches the i odd bus on each change of
   the forwarded clock once the first four after enable are dropped. assumes it runs on the sample clock. */
`timescale 1ns/1ps
module dacp_rx_model #(
  parameter int FLUSH = 4
) (
  // clock
  input wire        SYS_CLK,
  // forwarded link
  input wire        OUTPUT_DATA_CLOCK,
  input wire        DI_OE,
  input wire [7:0]  DI_ODD,
  // captured word
  output logic [7:0] word,
  output int         n_words
);
  logic output_data_clock_q = 1'b0; // clock level at the last edge
  int   skip   = FLUSH; // stale words still to drop
  initial word = 8'h00;
  initial n_words = 0;
  // the forwarded clock latches the i odd bus only; stale pipeline words are dropped
  always @(posedge SYS_CLK) begin
    output_data_clock_q <= OUTPUT_DATA_CLOCK;
    if (!DI_OE) skip <= FLUSH;
    else if (OUTPUT_DATA_CLOCK != output_data_clock_q) begin
      if (skip > 0) skip <= skip - 1;
      else begin
        word <= DI_ODD;
        n_words <= n_words + 1;
      end
    end
  end
endmodule

// ==== dacp_top_tb.sv ====
/* bench for dacp_top: power-on and manual calibration, output coding,
   demux, power down and registers. assumes short delay parameters. */
`timescale 1ns/1ps
module dacp_top_tb;
  logic SYS_CLK = 0, RST_N = 0, CAL_DELAY_SELECT = 0, CAL_DELAY_FLOAT = 0, SERIAL_PORT_SELECT_N = 1;
  logic CAL_REQUEST = 0, FULL_POWER_DOWN = 0, Q_CHANNEL_POWER_DOWN = 0, OUTPUT_EDGE_SELECT = 1;
  logic OUTPUT_SWING_SELECT = 1, REG_WR = 0, REG_RD = 0, DI_OE, DQ_OE, OUTPUT_DATA_CLOCK;
  logic OUTPUT_DRIVE_HIGH, CALIBRATION_ACTIVE, I_INPUT_ACTIVE, Q_INPUT_ACTIVE;
  logic [7:0]  I_SAMPLE = 8'h00, Q_SAMPLE = 8'h00, DI_ODD, DI_EVEN, DQ_ODD, DQ_EVEN, rx_word;
  logic [3:0]  REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA;
  logic [7:0]  v, smp [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
  int n_fail = 0, total_checks = 0, rx_n, n;
  dacp_top #(.DLY_SHORT(26'd64), .DLY_LONG(26'd256), .CAL_RUN(24'd100)) u_dacp_top (.*);
  dacp_rx_model u_dacp_rx_model (.SYS_CLK(SYS_CLK), .OUTPUT_DATA_CLOCK(OUTPUT_DATA_CLOCK), .DI_OE(DI_OE),
    .DI_ODD(DI_ODD), .word(rx_word), .n_words(rx_n));
  initial forever #2 SYS_CLK = ~SYS_CLK;
  task automatic tick(input int k);
    repeat (k) @(posedge SYS_CLK);
  endtask
  task automatic ce(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cr(input int g, lo, hi);
    total_checks++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("BAD %0t count %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // bounded wait for the calibration flag to reach a level
  task automatic wait_lv(input logic lv, input int lim, output int k);
    k = 0;
    while (CALIBRATION_ACTIVE !== lv && k < lim) begin
      @(posedge SYS_CLK);
      #1 k++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge SYS_CLK); REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1;
    @(posedge SYS_CLK); REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge SYS_CLK); REG_ADDR <= a; REG_RD <= 1'b1;
    @(posedge SYS_CLK); REG_RD <= 1'b0;
    #1 ce(REG_RDATA, e);
  endtask
  // power-up with pins set during reset; pd holds power down that long
  task automatic por(input logic s, f, sp, input int pd, lo);
    @(posedge SYS_CLK); RST_N <= 1'b0; CAL_DELAY_SELECT <= s & ~f; CAL_DELAY_FLOAT <= 1'b0;
    SERIAL_PORT_SELECT_N <= sp; FULL_POWER_DOWN <= (pd > 0);
    // a delay pin that is to float is held low through reset, floated only at release
    tick(4); RST_N <= 1'b1; CAL_DELAY_SELECT <= s; CAL_DELAY_FLOAT <= f;
    if (pd > 0) begin
      tick(pd); FULL_POWER_DOWN <= 1'b0;
    end
    wait_lv(1'b1, 2000, n); cr(n, lo, lo + 8);
    wait_lv(1'b0, 200, n); cr(n, 99, 102);
    $display("test power-up done");
  endtask
  // request low long enough, then high; lo/hi bound the start
  task automatic mcal(input int lo, hi);
    @(posedge SYS_CLK); CAL_REQUEST <= 1'b0; tick(1300);
    CAL_REQUEST <= 1'b1; wait_lv(1'b1, 1400, n); cr(n, lo, hi);
    @(posedge SYS_CLK); CAL_REQUEST <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000 n_fail++;
    close_out();
  end
  initial begin
    por(0, 0, 1, 0, 64);
    por(1, 0, 1, 0, 256);
    por(1, 0, 0, 0, 64);
    por(1, 1, 1, 0, 64);
    ce(16'({I_INPUT_ACTIVE, Q_INPUT_ACTIVE}), 16'h2);
    por(0, 0, 1, 300, 64);
    @(posedge SYS_CLK); CAL_REQUEST <= 1'b1; RST_N <= 1'b0;
    tick(4); RST_N <= 1'b1;
    wait_lv(1'b1, 400, n); cr(n, 400, 400);
    mcal(1280, 1290);
    wait_lv(1'b0, 200, n); cr(n, 99, 102);
    $display("test request strap done");
    // both launch edges, so the checker sees words change under each
    for (int e = 1; e >= 0; e--) begin
      @(posedge SYS_CLK); OUTPUT_EDGE_SELECT <= e[0]; tick(8);
      foreach (smp[i]) begin
        @(posedge SYS_CLK); I_SAMPLE <= smp[i]; tick(24);
        #1 ce(16'({DI_ODD, DI_EVEN}), 16'({2{smp[i] ^ 8'h80}}));
        ce(16'(rx_word), 16'(smp[i] ^ 8'h80));
      end
    end
    for (int e = 0; e < 2; e++) begin
      @(posedge SYS_CLK); OUTPUT_EDGE_SELECT <= e[0]; OUTPUT_SWING_SELECT <= e[0];
      for (int k = 0; k < 40; k++) begin
        @(posedge SYS_CLK); I_SAMPLE <= k[0] ? 8'h11 : 8'h22; Q_SAMPLE <= k[0] ? 8'h44 : 8'h88;
      end
      #1 ce(16'(OUTPUT_DRIVE_HIGH), 16'(e));
      ce(16'({DI_ODD ^ DI_EVEN, DQ_ODD ^ DQ_EVEN}), 16'h33cc);
    end
    @(posedge SYS_CLK); Q_CHANNEL_POWER_DOWN <= 1'b1; tick(8);
    #1 ce(16'({DI_OE, DQ_OE}), 16'h2);
    @(posedge SYS_CLK); Q_CHANNEL_POWER_DOWN <= 1'b0;
    $display("test data path done");
    wr(4'h1, 16'h0000);
    @(posedge SYS_CLK); SERIAL_PORT_SELECT_N <= 1'b0; tick(4);
    rd(4'h1, 16'h0006);
    rd(4'hd, 16'h0000);
    rd(4'h5, 16'h0000);
    wr(4'h1, 16'h0007);
    rd(4'h1, 16'h0007);
    tick(8);
    for (int k = 0; k < 8; k++) begin
      @(posedge SYS_CLK);
      #1 v[k] = OUTPUT_DATA_CLOCK;
    end
    ce(16'(v[5:0] ^ v[7:2]), 16'h003f);
    wr(4'hd, 16'ha000);
    tick(8);
    #1 ce(16'({I_INPUT_ACTIVE, Q_INPUT_ACTIVE}), 16'h1);
    rd(4'h2, 16'h0008);
    wr(4'hd, 16'h0000);
    @(posedge SYS_CLK); SERIAL_PORT_SELECT_N <= 1'b1;
    $display("test registers done");
    mcal(1280, 1290);
    wait_lv(1'b0, 200, n);
    @(posedge SYS_CLK); FULL_POWER_DOWN <= 1'b1; tick(10);
    mcal(1400, 1400);
    @(posedge SYS_CLK); FULL_POWER_DOWN <= 1'b0; tick(10);
    mcal(1280, 1290);
    FULL_POWER_DOWN <= 1'b1;
    wait_lv(1'b0, 300, n); cr(n, 90, 100);
    tick(8);
    #1 ce(16'({DI_OE, DQ_OE}), 16'h0);
    @(posedge SYS_CLK); FULL_POWER_DOWN <= 1'b0; tick(40);
    $display("test calibration done");
    close_out();
  end
endmodule
